// *** seis_pkg.sv ***
package seis_pkg;

  // Memory geometry
  localparam int unsigned MEM_BYTES  = 256;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned PAGE_W     = 4;

  // Slave address layout and bus levels
  localparam logic [3:0] SLV_PREAMBLE = 4'hA;
  localparam logic       RW_READ      = 1'h1;
  localparam logic       ACK_LVL      = 1'h0;
  localparam logic [7:0] ERASED       = 8'hFF;

  // Bit slot counter within a nine-clock byte frame
  localparam logic [3:0] BIT_FIRST  = 4'h0;
  localparam logic [3:0] BIT_LAST   = 4'h7;
  localparam logic [3:0] BIT_ACK    = 4'h8;
  localparam logic [3:0] BIT_RESYNC = 4'h2;
  localparam logic [3:0] BIT_STEP   = 4'h1;
  localparam logic [7:0] CTR_STEP   = 8'h01;

  // Timing at the 4 ns core clock
  localparam int unsigned CLK_NS     = 4;
  localparam int unsigned TWR_MS     = 5;
  localparam int unsigned WR_CYCLES  = TWR_MS * 1000000 / CLK_NS;
  localparam int unsigned QTR_NS     = 40;
  localparam int unsigned QTR_CYCLES = (QTR_NS + CLK_NS - 1) / CLK_NS;

  // Device bus states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SLAVE = 3'h1,
    ST_WADDR = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4
  } seis_dev_st_t;

  // Master commands
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP  = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ  = 2'h3
  } seis_op_t;

  // Master engine states
  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_STOP  = 2'h2,
    H_BIT   = 2'h3
  } seis_host_st_t;

endpackage

// *** seis_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface seis_bus_if;
  logic scl;
  logic sda;
  logic dev_sda_o;
  logic dev_sda_oe_b;
  logic host_sda_o;
  logic host_sda_oe_b;

  // Wired-AND line with pull-up; an enabled driver pulls the line low when its output is 0
  assign sda = ~((~dev_sda_oe_b & ~dev_sda_o) | (~host_sda_oe_b & ~host_sda_o));

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe_b
  );

  modport host (
    output scl,
    input  sda,
    output host_sda_o,
    output host_sda_oe_b
  );
endinterface
`default_nettype wire

// *** seis_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
module seis_dev #(
  parameter int unsigned WR_CYC = seis_pkg::WR_CYCLES
) (
  // Core clock and power-on reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Straps
  input  wire logic addr_select_bit0,
  input  wire logic addr_select_bit1,
  input  wire logic addr_select_bit2,
  input  wire logic write_protect,
  // Status
  output var  logic write_busy,
  // Serial bus
  seis_bus_if.dev   bus
);
  import seis_pkg::*;

  logic [7:0]          mem [MEM_BYTES];
  logic [7:0]          page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_mask;
  logic [PAGE_W-1:0]   page_sel;
  logic                armed;
  logic                scl_m;
  logic                scl_s;
  logic                sda_m;
  logic                sda_s;
  logic                sda_d;
  logic                armed_m;
  logic                armed_s;
  logic                frame_tgl;
  logic [31:0]         wr_timer;
  logic [PAGE_W:0]     commit_idx;
  logic                start_c;
  logic                stop_c;
  seis_dev_st_t        st;
  logic [3:0]          cnt;
  logic [7:0]          shreg;
  logic [7:0]          rx_byte;
  logic [7:0]          txb;
  logic [ADDR_W-1:0]   ctr;
  logic                ack;
  logic                seen;
  logic                wp_hold;
  logic                rstl_m;
  logic                rstl_s;
  logic                tgl_m;
  logic                tgl_s;
  logic                busy_m;
  logic                busy_s;
  logic                wp_m;
  logic                wp_s;
  logic [2:0]          sel_m;
  logic [2:0]          sel_s;

  // ---------------- Core clock domain ----------------

  // Bus pins and the armed level pass two flops before use
  always_ff @(posedge ref_clk) begin
    scl_m   <= bus.scl;
    scl_s   <= scl_m;
    sda_m   <= bus.sda;
    sda_s   <= sda_m;
    sda_d   <= sda_s;
    armed_m <= armed;
    armed_s <= armed_m;
  end

  // SDA edges while SCL is high are frame boundaries
  assign start_c = scl_s & sda_d & ~sda_s;
  assign stop_c  = scl_s & ~sda_d & sda_s;

  // Each START toggles the frame marker seen by the link side
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      frame_tgl <= 1'b0;
    end else if (start_c) begin
      frame_tgl <= ~frame_tgl;
    end
  end

  // Write cycle; SCL stands still after STOP so the core owns the commit
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      write_busy <= 1'b0;
      wr_timer   <= '0;
      commit_idx <= '0;
    end else if (!write_busy) begin
      if (stop_c && armed_s) begin
        write_busy <= 1'b1;
        wr_timer   <= '0;
        commit_idx <= '0;
      end
    end else begin
      if (!commit_idx[PAGE_W]) begin
        commit_idx <= (PAGE_W+1)'(commit_idx + 1'b1);
      end
      if (wr_timer == WR_CYC - 1) begin
        write_busy <= 1'b0;
      end else begin
        wr_timer <= wr_timer + 32'h1;
      end
    end
  end

  // Array starts erased; one buffered slot is committed per cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= ERASED;
      end
    end else if (write_busy && !commit_idx[PAGE_W] && page_mask[commit_idx[PAGE_W-1:0]]) begin
      mem[{page_sel, commit_idx[PAGE_W-1:0]}] <= page_buf[commit_idx[PAGE_W-1:0]];
    end
  end

  // ---------------- Link clock domain ----------------

  // Reset reaches the link side through two SCL flops
  always_ff @(posedge bus.scl) begin
    rstl_m <= rst_b;
    rstl_s <= rstl_m;
  end

  // Level crossings on the falling edge, ready before the next rise
  always_ff @(negedge bus.scl) begin
    tgl_m  <= frame_tgl;
    tgl_s  <= tgl_m;
    busy_m <= write_busy;
    busy_s <= busy_m;
    wp_m   <= write_protect;
    wp_s   <= wp_m;
    sel_m  <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
    sel_s  <= sel_m;
  end

  assign rx_byte = {shreg[6:0], bus.sda};

  // Receive side: bits taken on the rising edge
  always_ff @(posedge bus.scl) begin
    if (!rstl_s) begin
      st        <= ST_IDLE;
      cnt       <= BIT_FIRST;
      shreg     <= '0;
      ack       <= 1'b0;
      armed     <= 1'b0;
      page_mask <= '0;
      page_sel  <= '0;
      ctr       <= '0;
      txb       <= ERASED;
      seen      <= 1'b0;
    end else begin
      shreg <= rx_byte;
      if (tgl_s != seen) begin
        // START seen two edges late: the first two address bits are already in
        seen      <= tgl_s;
        st        <= ST_SLAVE;
        cnt       <= BIT_RESYNC;
        ack       <= 1'b0;
        armed     <= 1'b0;
        page_mask <= '0;
      end else if (cnt == BIT_ACK) begin
        cnt <= BIT_FIRST;
        ack <= 1'b0;
        if (st == ST_RDATA) begin
          if (bus.sda == ACK_LVL) begin
            txb <= mem[ctr];
          end else begin
            st <= ST_IDLE;
          end
        end
      end else begin
        cnt <= 4'(cnt + BIT_STEP);
        if (cnt == BIT_LAST) begin
          case (st)
            ST_SLAVE: begin
              if (rx_byte[7:4] == SLV_PREAMBLE && rx_byte[3:1] == sel_s && !busy_s) begin
                ack <= 1'b1;
                if (rx_byte[0] == RW_READ) begin
                  st  <= ST_RDATA;
                  txb <= mem[ctr];
                end else begin
                  st <= ST_WADDR;
                end
              end else begin
                st <= ST_IDLE;
              end
            end
            ST_WADDR: begin
              ctr <= rx_byte;
              ack <= 1'b1;
              st  <= ST_WDATA;
            end
            ST_WDATA: begin
              if (wp_hold) begin
                st <= ST_IDLE;
              end else begin
                page_buf[ctr[PAGE_W-1:0]]  <= rx_byte;
                page_mask[ctr[PAGE_W-1:0]] <= 1'b1;
                page_sel <= ctr[ADDR_W-1:PAGE_W];
                ctr      <= {ctr[ADDR_W-1:PAGE_W], PAGE_W'(ctr[PAGE_W-1:0] + BIT_STEP)};
                armed    <= 1'b1;
                ack      <= 1'b1;
              end
            end
            ST_RDATA: begin
              ctr <= 8'(ctr + CTR_STEP);
            end
            default: begin
              st <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Write-protect strobe on the fall just before the first data bit
  always_ff @(negedge bus.scl) begin
    if (!rstl_s) begin
      wp_hold <= 1'b0;
    end else if (st == ST_WDATA && cnt == BIT_FIRST && !armed) begin
      wp_hold <= wp_s;
    end
  end

  // Transmit side: changes only after the falling edge, open drain
  always_ff @(negedge bus.scl) begin
    bus.dev_sda_o <= 1'b0;
    if (!rstl_s) begin
      bus.dev_sda_oe_b <= 1'b1;
    end else if (cnt == BIT_ACK) begin
      bus.dev_sda_oe_b <= ~ack;
    end else if (st == ST_RDATA) begin
      bus.dev_sda_oe_b <= txb[3'(BIT_LAST - cnt)];
    end else begin
      bus.dev_sda_oe_b <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** seis_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module seis_host #(
  parameter int unsigned QTR = seis_pkg::QTR_CYCLES
) (
  // Core clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Command port
  input  wire logic             cmd_valid,
  input  wire seis_pkg::seis_op_t cmd_op,
  input  wire logic [7:0]       cmd_data,
  input  wire logic             cmd_nack,
  output var  logic             cmd_ready,
  // Answer
  output var  logic             done,
  output var  logic [7:0]       rd_data,
  output var  logic             ack_seen,
  // Serial bus
  seis_bus_if.host              bus
);
  import seis_pkg::*;

  seis_host_st_t st;
  logic [15:0]   qdiv;
  logic          tick;
  logic [1:0]    q;
  logic [3:0]    bits;
  logic [8:0]    tx;
  logic [8:0]    rx;
  logic          sda_m;
  logic          sda_s;

  // Returned SDA passes two flops
  always_ff @(posedge ref_clk) begin
    sda_m <= bus.sda;
    sda_s <= sda_m;
  end

  // Quarter-period divider derives SCL from the core clock
  always_ff @(posedge ref_clk) begin
    if (!rst_b || st == H_IDLE || tick) begin
      qdiv <= '0;
    end else begin
      qdiv <= qdiv + 16'h1;
    end
  end

  assign tick = (qdiv == 16'(QTR - 1));

  // Bus engine: each command takes four quarters per bit
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st                <= H_IDLE;
      q                 <= '0;
      bits              <= BIT_FIRST;
      tx                <= '1;
      rx                <= '0;
      cmd_ready         <= 1'b1;
      done              <= 1'b0;
      rd_data           <= '0;
      ack_seen          <= 1'b0;
      bus.scl           <= 1'b1;
      bus.host_sda_o    <= 1'b0;
      bus.host_sda_oe_b <= 1'b1;
    end else begin
      done <= 1'b0;
      case (st)
        H_IDLE: begin
          if (cmd_valid) begin
            cmd_ready <= 1'b0;
            q         <= '0;
            bits      <= BIT_FIRST;
            case (cmd_op)
              OP_START: st <= H_START;
              OP_STOP:  st <= H_STOP;
              OP_WRITE: begin
                tx <= {cmd_data, 1'b1};
                st <= H_BIT;
              end
              default: begin
                tx <= {ERASED, cmd_nack};
                st <= H_BIT;
              end
            endcase
          end
        end
        H_START: begin
          if (tick) begin
            q <= 2'(q + 1'b1);
            case (q)
              2'h0: bus.host_sda_oe_b <= 1'b1;
              2'h1: bus.scl <= 1'b1;
              2'h2: bus.host_sda_oe_b <= 1'b0;
              default: begin
                bus.scl   <= 1'b0;
                st        <= H_IDLE;
                done      <= 1'b1;
                cmd_ready <= 1'b1;
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            q <= 2'(q + 1'b1);
            case (q)
              2'h0: bus.host_sda_oe_b <= 1'b0;
              2'h1: bus.scl <= 1'b1;
              2'h2: bus.host_sda_oe_b <= 1'b1;
              default: begin
                st        <= H_IDLE;
                done      <= 1'b1;
                cmd_ready <= 1'b1;
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            q <= 2'(q + 1'b1);
            case (q)
              2'h0: bus.host_sda_oe_b <= tx[8]; // data set while SCL low
              2'h1: bus.scl <= 1'b1;
              2'h2: rx <= {rx[7:0], sda_s};
              default: begin
                bus.scl <= 1'b0;
                tx      <= {tx[7:0], 1'b1};
                if (bits == BIT_ACK) begin
                  rd_data   <= rx[8:1];
                  ack_seen  <= (rx[0] == ACK_LVL);
                  st        <= H_IDLE;
                  done      <= 1'b1;
                  cmd_ready <= 1'b1;
                end else begin
                  bits <= 4'(bits + BIT_STEP);
                end
              end
            endcase
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** seis_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module seis_asserts #(
  parameter int unsigned WR_CYC = seis_pkg::WR_CYCLES
) (
  // Core clock and device reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Serial bus
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_b,
  input wire logic host_sda_oe_b,
  // Straps and status
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic write_busy
);
  logic [3:0] bitn;
  logic [7:0] sh;
  logic       first;
  logic       rd;
  logic       seen;
  int         busy_n;
  int         since_stop;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Frame tracking; SCL rises counted in the core clock, reset by START
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bitn <= 4'h0;
      first <= 1'b0;
      rd <= 1'b0;
      seen <= 1'b0;
      sh <= 8'h00;
    end else if (scl && $fell(sda)) begin
      bitn <= 4'h0;
      first <= 1'b1;
      rd <= 1'b0;
      seen <= 1'b1;
    end else if (scl && $rose(sda)) begin
      first <= 1'b0;
      rd <= 1'b0;
    end else if ($rose(scl)) begin
      bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
      sh <= {sh[6:0], sda};
      if (bitn == 4'h8) begin
        first <= 1'b0;
        rd <= first ? (sh[0] & ~sda) : rd;
      end
    end
  end

  // Busy length and distance from the last STOP
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      busy_n <= 0;
      since_stop <= 100;
    end else begin
      busy_n <= write_busy ? busy_n + 1 : 0;
      since_stop <= (scl && $rose(sda)) ? 0 : (since_stop < 100) ? since_stop + 1 : since_stop;
    end
  end

  chk_od_low: assert property (dev_sda_o == 1'b0)
    else $error("device drives sda high");
  chk_dev_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_b))
    else $error("device changed sda while scl high");
  chk_start_by_host: assert property (scl && $past(scl) && $fell(sda) |-> $fell(host_sda_oe_b))
    else $error("start edge not made by host");
  chk_quiet_before: assert property (!seen |-> dev_sda_oe_b)
    else $error("device drove before any start");
  chk_ack_slot: assert property ($rose(scl) && !dev_sda_oe_b && !rd |-> bitn == 4'h8)
    else $error("device pulled sda outside ack clock");
  chk_read_release: assert property ($rose(scl) && rd && bitn == 4'h8 |-> dev_sda_oe_b)
    else $error("device held sda in read ack clock");
  chk_addr_match: assert property ($rose(scl) && first && bitn == 4'h8 && !dev_sda_oe_b
    |-> sh[7:1] == {4'hA, addr_select_bit2, addr_select_bit1, addr_select_bit0})
    else $error("device acked a foreign address");
  chk_busy_refuse: assert property ($rose(scl) && first && bitn == 4'h8 && write_busy |-> dev_sda_oe_b)
    else $error("address acked while busy");
  chk_busy_len: assert property ($fell(write_busy) |-> busy_n <= WR_CYC && busy_n + 4 >= WR_CYC)
    else $error("write cycle length wrong");
  chk_busy_after_stop: assert property ($rose(write_busy) |-> since_stop < 8)
    else $error("write cycle not launched by stop");

  // Main scenarios reached
  cover property ($rose(scl) && first && bitn == 4'h8 && !dev_sda_oe_b);
  cover property ($rose(scl) && rd && bitn == 4'h8 && !sda);
  cover property ($rose(write_busy));
endmodule
`default_nettype wire

// *** seis_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module seis_tb;
  import seis_pkg::*;
  localparam int unsigned WR = 2000;
  // Stimulus, responses and model
  logic       ref_clk;
  logic       rst_b;
  logic       host_rst_b;
  logic       cmd_valid;
  seis_op_t   cmd_op;
  logic [7:0] cmd_data;
  logic       cmd_nack;
  logic       write_protect;
  logic [2:0] sel;
  logic       cmd_ready;
  logic       done;
  logic [7:0] rd_data;
  logic       ack_seen;
  logic       write_busy;
  logic [7:0] mem [256];
  logic [7:0] ctr;
  logic [7:0] a;
  int         fail_count;
  int         checked;
  int         seed;
  int         j;
  seis_bus_if bus ();

  seis_dev #(.WR_CYC(WR)) seis_dev_inst (.ref_clk(ref_clk), .rst_b(rst_b), .addr_select_bit0(sel[0]),
    .addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]), .write_protect(write_protect),
    .write_busy(write_busy), .bus(bus));
  seis_host #(.QTR(10)) seis_host_inst (.ref_clk(ref_clk), .rst_b(host_rst_b), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready), .done(done),
    .rd_data(rd_data), .ack_seen(ack_seen), .bus(bus));
  seis_asserts #(.WR_CYC(WR)) seis_asserts_inst (.ref_clk(ref_clk), .rst_b(rst_b), .scl(bus.scl),
    .sda(bus.sda), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe_b(bus.dev_sda_oe_b),
    .host_sda_oe_b(bus.host_sda_oe_b), .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
    .addr_select_bit2(sel[2]), .write_busy(write_busy));

  // Core clock, 4 ns
  always #2 ref_clk = ~ref_clk;

  // One host command; request held until the taking edge
  task automatic cmd(input seis_op_t op, input logic [7:0] dd, input logic nk);
    int k;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = dd;
    cmd_nack = nk;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 2000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 2000) begin
      fail_count++;
      $display("[FAIL] %0t no done", $time);
    end
  endtask

  function automatic logic [7:0] sa(input logic rw);
    return {4'hA, sel, rw};
  endfunction

  task automatic wb(input logic [7:0] dd, input logic ex);
    cmd(OP_WRITE, dd, 1'b0);
    `CHK(ack_seen, ex)
  endtask

  // Write cnt random bytes from ad; model follows the in-page wrap
  task automatic wr(input logic [7:0] ad, input int cnt, input logic wp);
    logic [7:0] dd;
    @(negedge ref_clk);
    write_protect = wp;
    cmd(OP_START, 8'h00, 1'b0);
    wb(sa(1'b0), 1'b1);
    wb(ad, 1'b1);
    for (int i = 0; i < cnt; i++) begin
      dd = 8'($random(seed));
      wb(dd, !wp);
      if (!wp) begin
        mem[ad] = dd;
        ad[3:0] = ad[3:0] + 4'h1;
      end
    end
    cmd(OP_STOP, 8'h00, 1'b0);
    @(negedge ref_clk);
    write_protect = 1'b0;
  endtask

  // Acknowledge polling after a write
  task automatic poll(input logic bz);
    `CHK(write_busy, bz)
    for (int n = 0; n < 40; n++) begin
      cmd(OP_START, 8'h00, 1'b0);
      cmd(OP_WRITE, sa(1'b0), 1'b0);
      cmd(OP_STOP, 8'h00, 1'b0);
      if (n == 0) `CHK(ack_seen, !bz)
      if (ack_seen === 1'b1) break;
    end
    `CHK(ack_seen, 1'b1)
  endtask

  // Read cnt bytes, optionally from a chosen address; last one refused
  task automatic rd(input logic [7:0] ad, input int cnt, input logic pick);
    if (pick) begin
      cmd(OP_START, 8'h00, 1'b0);
      wb(sa(1'b0), 1'b1);
      wb(ad, 1'b1);
      ctr = ad;
    end
    cmd(OP_START, 8'h00, 1'b0);
    wb(sa(1'b1), 1'b1);
    for (int i = 0; i < cnt; i++) begin
      cmd(OP_READ, 8'h00, i == cnt - 1);
      `CHK(rd_data, mem[ctr])
      ctr = ctr + 8'h01;
    end
    cmd(OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic test_done;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog, well past the expected run
  initial begin
    #300000;
    fail_count++;
    $display("[FAIL] %0t watchdog", $time);
    test_done;
  end

  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    host_rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    write_protect = 1'b0;
    fail_count = 0;
    checked = 0;
    seed = 32'h2015;
    sel = 3'($random(seed));
    for (j = 0; j < 256; j++) mem[j] = 8'hFF;
    repeat (10) @(negedge ref_clk);
    host_rst_b = 1'b1;
    // Link side of the device resets on SCL rises only
    cmd(OP_START, 8'h00, 1'b0);
    cmd(OP_WRITE, 8'h00, 1'b0);
    cmd(OP_STOP, 8'h00, 1'b0);
    @(negedge ref_clk);
    rst_b = 1'b1;
    // Release reaches the link side two SCL rises late; a foreign-address frame spends them
    cmd(OP_START, 8'h00, 1'b0);
    wb(8'h00, 1'b0);
    cmd(OP_STOP, 8'h00, 1'b0);
    rd(8'hFE, 4, 1'b1);
    rd(8'h00, 2, 1'b0);
    $display("test read wrap done");
    // Slot 7 has the right pins but the wrong preamble
    for (j = 0; j < 8; j++) begin
      cmd(OP_START, 8'h00, 1'b0);
      wb({j == 7 ? 4'h6 : 4'hA, sel ^ (j == 7 ? 3'h0 : 3'(j)), 1'b0}, j == 0);
      cmd(OP_STOP, 8'h00, 1'b0);
    end
    $display("test address match done");
    a = 8'($random(seed));
    wr(a, 18, 1'b0);
    poll(1'b1);
    rd({a[7:4], 4'h0}, 16, 1'b1);
    $display("test page write done");
    wr(a, 1, 1'b1);
    poll(1'b0);
    rd(a, 1, 1'b1);
    $display("test write protect done");
    cmd(OP_START, 8'h00, 1'b0);
    wb(sa(1'b0), 1'b1);
    wb(a, 1'b1);
    wb(~mem[a], 1'b1);
    cmd(OP_START, 8'h00, 1'b0);
    wb(sa(1'b0), 1'b1);
    cmd(OP_STOP, 8'h00, 1'b0);
    repeat (20) @(negedge ref_clk);
    `CHK(write_busy, 1'b0)
    rd(a, 1, 1'b1);
    $display("test repeated start done");
    for (j = 0; j < 3; j++) begin
      a = 8'($random(seed));
      wr(a, 1, 1'b0);
      poll(1'b1);
      rd(a, 1, 1'b1);
    end
    $display("test random writes done");
    test_done;
  end
endmodule
`default_nettype wire
